// ---- rtl/fpo_pkg.sv ----
// constants and types for the flash protection and overlay block
package fpo_pkg;

    // key codes that unlock download and program/erase
    localparam logic [7:0]  KEY_DL        = 8'hA5;
    localparam logic [7:0]  KEY_PE        = 8'h5A;
    localparam logic [7:0]  KEY_RST       = 8'h00;

    // reset values of the interface registers
    localparam logic        DL_REQ_RST    = 1'b0;
    localparam logic [7:0]  DL_ADDR_RST   = 8'h00;
    localparam logic        MAT_BOOT_RST  = 1'b0;
    localparam logic [2:0]  BLK_SEL_RST   = 3'h0;

    // program/erase result codes
    localparam logic [7:0]  RES_OK        = 8'h00;
    localparam logic [7:0]  RES_PROT      = 8'h01;
    localparam logic [7:0]  RES_ERR       = 8'h02;

    // address map: eight 4 KB user-array blocks from 0, overlay ram window
    localparam int          ADDR_W        = 24;
    localparam int          DATA_W        = 32;
    localparam int          BLK_OFF_W     = 12;
    localparam int          RAM_AW        = 10;
    localparam logic [11:0] BLK_BASE_HI   = 12'h000;
    localparam logic [11:0] RAM_WIN_HI    = 12'hFF8;
    localparam logic [23:0] BOOT_SIZE     = 24'h00_2800;

    // minimum reset hold before error protection is released
    localparam int          RST_HOLD_US   = 100;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          RST_HOLD_CYC  = (RST_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int          RST_CNT_W     = 11;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [23:0] addr;
        logic [31:0] wdata;
    } fpo_acc_t;

    typedef struct packed {
        logic       en;
        logic [2:0] blk;
    } fpo_ovl_t;

    typedef struct packed {
        logic irq;
        logic nmi;
        logic flash_rd;
        logic sleep;
        logic other_master;
    } fpo_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_ERR  = 2'b10
    } fpo_state_t;

endpackage

// ---- rtl/fpo_ram.sv ----
// overlay ram storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module fpo_ram (
    input  wire logic                      core_clk,
    input  wire logic                      en,
    input  wire logic                      we,
    input  wire logic [fpo_pkg::RAM_AW-1:0] addr,
    input  wire logic [fpo_pkg::DATA_W-1:0] wdata,
    output logic      [fpo_pkg::DATA_W-1:0] rdata_q
);
    import fpo_pkg::*;

    logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

    // no reset on the array; read data is only meaningful after a read
    always_ff @(posedge core_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (en && !we) begin
            rdata_q <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/fpo_top.sv ----
// flash program/erase protection, ram overlay and array switching
//
// How it works
// (R1) any reset restores registers, enters protection
// (R2) hardware protection allows download, init; refuses program
// (R3) download bit clear blocks download and program
// (R4) wrong key blocks download and program/erase
// (R5) software loads A5, 5A, then clears key
// (R6) overlay enabled protects all blocks, refuses download
// (R7) error aborts operation, sets error flag
// (R8) interrupt during program/erase triggers error
// (R9) flash read during program/erase triggers error
// (R10) sleep during program/erase triggers error
// (R11) other bus master during program/erase triggers error
// (R12) only long reset leaves error protection
// (R13) overlay maps ram onto one of eight blocks
// (R14) enable with select zero overlays first block
// (R15) block range and ram window share storage
// (R16) overlay works in user and user program modes
// (R17) software keeps download area off tuned data
// (R18) software waits eight nops after array switch
// (R19) software masks interrupts during array switch
// (R20) both arrays share base; boot array blocks programming
// (R21) boot array reads past 10 KB undefined
// (R22) array switch also switches the vector table
// (R23) error flag readable, not software clearable
`timescale 1ns/1ps
`default_nettype none
module fpo_top (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              key_wr,
    input  wire logic [7:0]        key_wdata,
    input  wire logic              dl_req_wr,
    input  wire logic              dl_req_wdata,
    input  wire logic              ovl_wr,
    input  wire fpo_pkg::fpo_ovl_t ovl_wdata,
    input  wire logic              dl_addr_wr,
    input  wire logic [7:0]        dl_addr_wdata,
    input  wire logic              mat_wr,
    input  wire logic              mat_boot_wdata,
    input  wire logic              init_start,
    input  wire logic              pe_start,
    input  wire logic              pe_done,
    input  wire fpo_pkg::fpo_evt_t evt,
    input  wire fpo_pkg::fpo_acc_t acc,
    output logic [7:0]             key_q,
    output logic                   dl_req_q,
    output fpo_pkg::fpo_ovl_t      ovl_q,
    output logic [7:0]             dl_addr_q,
    output logic                   mat_boot_q,
    output logic                   dl_go_q,
    output logic                   init_go_q,
    output logic                   pe_run_q,
    output logic                   err_q,
    output logic [7:0]             res_q,
    output fpo_pkg::fpo_acc_t      flash_req_q,
    output logic                   boot_oob_q,
    output logic                   ram_rd_valid_q,
    output logic [31:0]            ram_rdata_q
);
    import fpo_pkg::*;

    fpo_state_t             st_q;
    logic [RST_CNT_W-1:0]   rst_cnt_q;
    logic                   long_rst;
    logic                   ram_hit;
    logic                   ovl_hit;
    logic                   mem_hit;
    logic                   flash_acc;
    logic                   err_evt;
    logic                   dl_try;
    logic                   dl_ok;
    logic                   pe_ok;

    // address decode; overlay alias and ram window land in one store
    assign ram_hit   = acc.valid && (acc.addr[23:12] == RAM_WIN_HI);                 // R15
    assign ovl_hit   = acc.valid && ovl_q.en                                         // R13
                       && (acc.addr[23:12] == (BLK_BASE_HI | {9'h000, ovl_q.blk})); // R14
    assign mem_hit   = ram_hit || ovl_hit;                                           // R16
    assign flash_acc = acc.valid && !mem_hit;

    // download needs the bit, the download key and no overlay
    assign dl_try = dl_req_wr && dl_req_wdata;
    assign dl_ok  = dl_try && (key_q == KEY_DL)                                      // R4
                    && !ovl_q.en && !err_q;                                          // R6

    // program/erase needs bit, key, no overlay, user array, no error
    assign pe_ok = pe_start && (st_q == ST_IDLE) && !err_q
                   && dl_req_q                                                       // R3
                   && (key_q == KEY_PE)                                              // R4
                   && !ovl_q.en                                                      // R6
                   && !mat_boot_q;                                                   // R20

    // any forbidden event while busy aborts the operation
    assign err_evt = (st_q == ST_BUSY)
                     && (evt.irq || evt.nmi                                          // R8
                         || evt.flash_rd || flash_acc                                // R9
                         || evt.sleep                                                // R10
                         || evt.other_master);                                       // R11

    // error protection survives a reset shorter than the hold time
    assign long_rst = (rst_cnt_q >= RST_CNT_W'(RST_HOLD_CYC - 1));

    always_ff @(posedge core_clk) begin
        if (!reset) begin
            rst_cnt_q <= '0;
        end else if (!long_rst) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end
    end

    // key register, cleared by software when done
    always_ff @(posedge core_clk) begin
        if (reset) begin
            key_q <= KEY_RST;                                                        // R1
        end else if (key_wr) begin
            key_q <= key_wdata;                                                      // R5
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dl_req_q <= DL_REQ_RST;                                                  // R1
        end else if (dl_req_wr) begin
            dl_req_q <= dl_req_wdata;                                                // R3
        end
    end

    // overlay control; not changed mid-operation to keep the map stable
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ovl_q.en  <= 1'b0;                                                       // R1
            ovl_q.blk <= BLK_SEL_RST;
        end else if (ovl_wr && (st_q != ST_BUSY)) begin
            ovl_q <= ovl_wdata;                                                      // R13
        end
    end

    // download destination; placing it clear of tuned data is up to software
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dl_addr_q <= DL_ADDR_RST;                                                // R1
        end else if (dl_addr_wr) begin
            dl_addr_q <= dl_addr_wdata;                                              // R17
        end
    end

    // array select; both arrays decode from base 0, vectors follow
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mat_boot_q <= MAT_BOOT_RST;                                              // R1
        end else if (mat_wr && (st_q != ST_BUSY)) begin
            mat_boot_q <= mat_boot_wdata;                                            // R22
        end
    end

    // download and init launch pulses
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dl_go_q   <= 1'b0;
            init_go_q <= 1'b0;
        end else begin
            dl_go_q   <= dl_ok;                                                      // R3
            init_go_q <= init_start && !err_q;                                       // R2
        end
    end

    // program/erase sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;                                                         // R1
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (pe_ok) begin
                        st_q <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (err_evt) begin
                        st_q <= ST_ERR;                                              // R7
                    end else if (pe_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_ERR: begin
                    st_q <= ST_ERR;                                                  // R12
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pe_run_q <= 1'b0;
        end else if (err_evt) begin
            pe_run_q <= 1'b0;                                                        // R7
        end else if (pe_ok) begin
            pe_run_q <= 1'b1;
        end else if (pe_done) begin
            pe_run_q <= 1'b0;
        end
    end

    // error flag: no software path clears it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            if (long_rst) begin
                err_q <= 1'b0;                                                       // R12
            end
        end else if (err_evt) begin
            err_q <= 1'b1;                                                           // R23
        end
    end

    // result parameter seen by the procedure program
    always_ff @(posedge core_clk) begin
        if (reset) begin
            res_q <= RES_OK;                                                         // R1
        end else if (err_evt) begin
            res_q <= RES_ERR;                                                        // R7
        end else if (pe_start && !pe_ok && (st_q != ST_BUSY)) begin
            res_q <= err_q ? RES_ERR : RES_PROT;                                     // R2
        end else if (dl_try && !dl_ok) begin
            res_q <= RES_PROT;                                                       // R6
        end else if (pe_ok || dl_ok || ((st_q == ST_BUSY) && pe_done)) begin
            res_q <= RES_OK;
        end
    end

    // flash reads pass on only in the idle state; flash writes never pass
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flash_req_q <= '0;
            boot_oob_q  <= 1'b0;
        end else begin
            flash_req_q       <= acc;
            flash_req_q.valid <= flash_acc && !acc.wr && (st_q == ST_IDLE);          // R9
            boot_oob_q        <= flash_acc && mat_boot_q && (acc.addr >= BOOT_SIZE); // R21
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ram_rd_valid_q <= 1'b0;
        end else begin
            ram_rd_valid_q <= mem_hit && !acc.wr;                                    // R15
        end
    end

    // one store reached from both the block alias and the window
    fpo_ram u_ram (
        .core_clk (core_clk),
        .en       (mem_hit),
        .we       (acc.wr),
        .addr     (acc.addr[BLK_OFF_W-1:2]),
        .wdata    (acc.wdata),
        .rdata_q  (ram_rdata_q)
    );

    property p_reset_init;
        @(posedge core_clk) disable iff (1'b0)
        reset |=> (key_q == KEY_RST) && !dl_req_q && !pe_run_q && !ovl_q.en;
    endproperty
    a_reset_init: assert property (p_reset_init) // R1
        else $error("registers not initialised by reset");

    property p_dl_key;
        @(posedge core_clk) disable iff (reset)
        dl_go_q |-> ($past(key_q) == KEY_DL) && !$past(ovl_q.en);
    endproperty
    a_dl_key: assert property (p_dl_key) // R6
        else $error("download without key or with overlay on");

    property p_pe_gate;
        @(posedge core_clk) disable iff (reset)
        $rose(pe_run_q) |-> $past(dl_req_q) && ($past(key_q) == KEY_PE);
    endproperty
    a_pe_gate: assert property (p_pe_gate) // R4
        else $error("program/erase started without bit or key");

    property p_pe_prot;
        @(posedge core_clk) disable iff (reset)
        $rose(pe_run_q) |-> !$past(ovl_q.en) && !$past(mat_boot_q);
    endproperty
    a_pe_prot: assert property (p_pe_prot) // R20
        else $error("program/erase under overlay or boot array");

    property p_irq_abort;
        @(posedge core_clk) disable iff (reset)
        pe_run_q && (evt.irq || evt.nmi) |=> err_q && !pe_run_q && (res_q == RES_ERR);
    endproperty
    a_irq_abort: assert property (p_irq_abort) // R8
        else $error("interrupt during program/erase not caught");

    property p_rd_abort;
        @(posedge core_clk) disable iff (reset)
        pe_run_q && flash_acc |=> err_q ##1 !flash_req_q.valid;
    endproperty
    a_rd_abort: assert property (p_rd_abort) // R9
        else $error("flash read during program/erase not caught");

    property p_err_sticky;
        @(posedge core_clk) disable iff (reset)
        err_q |=> err_q [*3];
    endproperty
    a_err_sticky: assert property (p_err_sticky) // R23
        else $error("error flag dropped without reset");

    property p_refuse;
        @(posedge core_clk) disable iff (reset)
        pe_start && !pe_ok && !err_evt && !pe_run_q |=> !pe_run_q && (res_q != RES_OK);
    endproperty
    a_refuse: assert property (p_refuse) // R2
        else $error("refused program/erase not reported");

    property p_short_rst;
        @(posedge core_clk) disable iff (1'b0)
        err_q && reset && !long_rst |=> err_q;
    endproperty
    a_short_rst: assert property (p_short_rst) // R12
        else $error("error protection left by a short reset");

    property p_long_rst;
        @(posedge core_clk) disable iff (1'b0)
        reset && long_rst |=> !err_q;
    endproperty
    a_long_rst: assert property (p_long_rst) // R12
        else $error("error protection kept after a long reset");

    property p_sleep_abort;
        @(posedge core_clk) disable iff (reset)
        pe_run_q && evt.sleep |=> err_q && !pe_run_q && (res_q == RES_ERR);
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) // R10
        else $error("sleep during program/erase not caught");

    // a second master may fetch from flash behind the cpu's back
    property p_master_abort;
        @(posedge core_clk) disable iff (reset)
        pe_run_q && evt.other_master |=> err_q && !pe_run_q && (res_q == RES_ERR);
    endproperty
    a_master_abort: assert property (p_master_abort) // R11
        else $error("other bus master during program/erase not caught");
endmodule
`default_nettype wire

// ---- bench/fpo_flash_engine.sv ----
// flash engine model: answers a running program/erase with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_engine (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       pe_run_q,
    input  wire logic [7:0] busy_cycles,
    output logic            pe_done
);
    logic [7:0] cnt_q;
    // a slow setting keeps the run open long enough to inject faults
    always_ff @(posedge core_clk) begin
        if (reset || !pe_run_q) begin
            cnt_q   <= 8'h00;
            pe_done <= 1'b0;
        end else begin
            cnt_q   <= cnt_q + 8'h01;
            pe_done <= (cnt_q == busy_cycles);
        end
    end
endmodule
`default_nettype wire

// ---- bench/test_fpo_top.sv ----
// self-checking bench for flash protection, ram overlay and array switching
`timescale 1ns/1ps
`default_nettype none
module test_fpo_top;
    import fpo_pkg::*;
    localparam int W_KEY = 0, W_DLR = 1, W_OVL = 2, W_MAT = 3, W_PE = 4, W_INIT = 5;
    localparam int W_DLA = 6;
    logic        core_clk, reset, key_wr, dl_req_wr, dl_req_wdata, ovl_wr, dl_addr_wr;
    logic        mat_wr, mat_boot_wdata, init_start, pe_start, pe_done;
    logic [7:0]  key_wdata, dl_addr_wdata, key_q, dl_addr_q, res_q, busy_cycles;
    logic        dl_req_q, mat_boot_q, dl_go_q, init_go_q, pe_run_q, err_q;
    logic        boot_oob_q, ram_rd_valid_q;
    logic [31:0] ram_rdata_q;
    fpo_ovl_t    ovl_wdata, ovl_q;
    fpo_evt_t    evt;
    fpo_acc_t    acc, flash_req_q;
    int          num_errors = 0, check_count = 0, cycles = 0;

    fpo_top uut (
        .core_clk, .reset, .key_wr, .key_wdata, .dl_req_wr, .dl_req_wdata, .ovl_wr,
        .ovl_wdata, .dl_addr_wr, .dl_addr_wdata, .mat_wr, .mat_boot_wdata, .init_start,
        .pe_start, .pe_done, .evt, .acc, .key_q, .dl_req_q, .ovl_q, .dl_addr_q,
        .mat_boot_q, .dl_go_q, .init_go_q, .pe_run_q, .err_q, .res_q, .flash_req_q,
        .boot_oob_q, .ram_rd_valid_q, .ram_rdata_q
    );
    fpo_flash_engine eng (.core_clk, .reset, .pe_run_q, .busy_cycles, .pe_done);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // the ceiling covers eight long and six 999-cycle short resets plus all other scenarios
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 25000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic do_reset(input int n);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (n) @(posedge core_clk);
        reset <= 1'b0;
        #1;
    endtask

    // one-cycle write or request strobe; outputs are settled on return
    task automatic wr(input int sel, input logic [7:0] v);
        @(posedge core_clk);
        case (sel)
            W_KEY: begin key_wr <= 1'b1; key_wdata <= v; end
            W_DLR: begin dl_req_wr <= 1'b1; dl_req_wdata <= v[0]; end
            W_OVL: begin ovl_wr <= 1'b1; ovl_wdata <= fpo_ovl_t'(v[3:0]); end
            W_MAT: begin mat_wr <= 1'b1; mat_boot_wdata <= v[0]; end
            W_PE: pe_start <= 1'b1;
            W_INIT: init_start <= 1'b1;
            default: begin dl_addr_wr <= 1'b1; dl_addr_wdata <= v; end
        endcase
        @(posedge core_clk);
        {key_wr, dl_req_wr, ovl_wr, mat_wr, pe_start, init_start, dl_addr_wr} <= 7'h00;
        #1;
    endtask

    task automatic access(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge core_clk);
        acc <= '{valid: 1'b1, wr: w, addr: a, wdata: d};
        @(posedge core_clk);
        acc <= '0;
        #1;
    endtask

    task automatic arm_pe();
        wr(W_KEY, KEY_DL);
        wr(W_DLR, 8'h01);
        wr(W_KEY, KEY_PE);
    endtask

    task automatic t_reset_values();
        do_reset(1000);
        check({key_q, dl_addr_q, res_q, ovl_q, dl_req_q, mat_boot_q, pe_run_q, err_q},
              {KEY_RST, DL_ADDR_RST, RES_OK, 4'h0, DL_REQ_RST, MAT_BOOT_RST, 2'b00});
        check({dl_go_q, init_go_q, flash_req_q.valid}, 3'h0);
    endtask

    task automatic t_download();
        wr(W_INIT, 8'h00);
        check(init_go_q, 1'b1);
        wr(W_DLR, 8'h01);
        check({dl_go_q, res_q}, {1'b0, RES_PROT});
        wr(W_KEY, KEY_DL);
        wr(W_DLR, 8'h01);
        check({dl_go_q, dl_req_q, res_q}, {2'b11, RES_OK});
        wr(W_KEY, KEY_PE);
        wr(W_DLR, 8'h00);
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b0, RES_PROT});
        arm_pe();
        wr(W_KEY, KEY_RST);
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b0, RES_PROT});
    endtask

    task automatic t_pe_ok();
        busy_cycles <= 8'h05;
        arm_pe();
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b1, RES_OK});
        wr(W_OVL, 8'h0B);
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b1, RES_OK});
        for (int k = 0; k < 50 && pe_run_q; k++) begin
            @(posedge core_clk);
            #1;
        end
        check({pe_run_q, res_q, err_q, ovl_q}, {1'b0, RES_OK, 1'b0, 4'h0});
        wr(W_KEY, KEY_RST);
    endtask

    task automatic t_protect();
        wr(W_OVL, 8'h0B);
        wr(W_KEY, KEY_DL);
        wr(W_DLR, 8'h01);
        check({dl_go_q, res_q}, {1'b0, RES_PROT});
        wr(W_KEY, KEY_PE);
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b0, RES_PROT});
        wr(W_OVL, 8'h00);
        arm_pe();
        wr(W_MAT, 8'h01);
        repeat (8) @(posedge core_clk);
        wr(W_PE, 8'h00);
        check({pe_run_q, res_q}, {1'b0, RES_PROT});
        wr(W_MAT, 8'h00);
        repeat (8) @(posedge core_clk);
        wr(W_KEY, KEY_RST);
    endtask

    task automatic t_overlay();
        wr(W_DLA, 8'h02);
        check(dl_addr_q, 8'h02);
        for (int b = 0; b < 8; b++) begin
            wr(W_OVL, {4'h0, 1'b1, b[2:0]});
            access(1'b1, 24'hFF_8000 + 24'(b * 4), 32'h5A00_0000 + 32'(b));
            access(1'b0, 24'(b * 32'h0000_1004), '0);
            check({ram_rd_valid_q, ram_rdata_q}, {1'b1, 32'h5A00_0000 + 32'(b)});
            access(1'b0, 24'((b ^ 1) * 32'h0000_1000), '0);
            check({ram_rd_valid_q, flash_req_q.valid}, 2'b01);
        end
        wr(W_OVL, 8'h08);
        access(1'b1, 24'h00_0008, 32'hC3C3_3C3C);
        access(1'b0, 24'hFF_8008, '0);
        check({ram_rd_valid_q, ram_rdata_q}, {1'b1, 32'hC3C3_3C3C});
        wr(W_OVL, 8'h00);
        access(1'b0, 24'h00_0008, '0);
        check({ram_rd_valid_q, flash_req_q.valid}, 2'b01);
    endtask

    task automatic t_boot();
        wr(W_MAT, 8'h01);
        repeat (8) @(posedge core_clk);
        access(1'b0, 24'h00_0000, '0);
        check({flash_req_q.valid, flash_req_q.addr, boot_oob_q}, {1'b1, 24'h00_0000, 1'b0});
        access(1'b0, BOOT_SIZE - 24'h00_0004, '0);
        check({flash_req_q.valid, boot_oob_q}, 2'b10);
        access(1'b0, BOOT_SIZE, '0);
        check({flash_req_q.valid, boot_oob_q}, 2'b11);
        wr(W_MAT, 8'h00);
        repeat (8) @(posedge core_clk);
        access(1'b0, BOOT_SIZE, '0);
        check({flash_req_q.valid, boot_oob_q}, 2'b10);
    endtask

    // one fault source per pass: five event lines, then a flash read
    task automatic t_errors();
        for (int i = 0; i < 6; i++) begin
            do_reset(1000);
            busy_cycles <= 8'hC8;
            arm_pe();
            wr(W_PE, 8'h00);
            check(pe_run_q, 1'b1);
            if (i < 5) begin
                @(posedge core_clk);
                evt <= fpo_evt_t'(5'h01 << i);
                @(posedge core_clk);
                evt <= '0;
                #1;
            end else begin
                access(1'b0, 24'h00_1000, '0);
            end
            check({err_q, pe_run_q, res_q}, {2'b10, RES_ERR});
            do_reset(999);
            check({err_q, key_q, dl_req_q}, {1'b1, KEY_RST, 1'b0});
            arm_pe();
            wr(W_PE, 8'h00);
            check({pe_run_q, res_q}, {1'b0, RES_ERR});
        end
        do_reset(1000);
        check(err_q, 1'b0);
    endtask

    initial begin
        reset = 1'b1;
        {key_wr, dl_req_wr, dl_req_wdata, ovl_wr, dl_addr_wr, mat_wr} = 6'h00;
        {mat_boot_wdata, init_start, pe_start} = 3'h0;
        {key_wdata, dl_addr_wdata} = 16'h0000;
        busy_cycles = 8'h05;
        ovl_wdata = '0;
        evt = '0;
        acc = '0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        t_reset_values();
        t_download();
        t_pe_ok();
        t_protect();
        t_overlay();
        t_boot();
        t_errors();
        summarize();
    end
endmodule
`default_nettype wire
